// ---- sim/lcc_light_conv_ctrl_assertions.sv ----
// Purpose: Concurrent checks on the conversion control ports.
// Assumes: Bound to lcc_light_conv_ctrl, one clock domain.
// Notes:   Conversion counts arrive as parameters through the bind.
`default_nettype none
module lcc_checker #(
  parameter int unsigned SHORT_CYC = 20,
  parameter int unsigned LONG_CYC  = 50
) (
  input wire logic                       i_clk,
  input wire logic                       i_nrst,
  input wire logic                       i_psel,
  input wire logic                       i_penable,
  input wire logic                       i_pwrite,
  input wire logic [lcc_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0]                i_pwdata,
  input wire logic [31:0]                o_prdata,
  input wire logic                       o_pready,
  input wire logic                       o_pslverr,
  input wire logic                       i_adc_overload,
  input wire logic [11:0]                i_adc_mantissa,
  input wire logic                       o_adc_run,
  input wire logic                       o_adc_clear,
  input wire logic [3:0]                 o_adc_range,
  input wire logic                       o_adc_long,
  input wire logic                       o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic        wr;
  logic        go;
  logic [31:0] run_q;
  assign wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr == 8'h00;
  assign go = wr && i_pwdata[10:9] != 2'h0;
  // Cycles of integration since the last clear pulse.
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      run_q <= 32'h0;
    else
      run_q <= (o_adc_run && !o_adc_clear) ? run_q + 32'h1 : 32'h0;
  setup_ready_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  slverr_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  start_conv_a: assert property (go |=> o_adc_clear && o_adc_run)
    else $error("write did not start conversion");
  abort_conv_a: assert property (wr && !go |=> !o_adc_run)
    else $error("write did not abort conversion");
  conv_time_a: assert property (
    go |=> o_adc_long == $past(i_pwdata[11]))
    else $error("wrong conversion length select");
  manual_range_a: assert property (
    go && i_pwdata[15:12] < 4'hC |=> o_adc_range == $past(i_pwdata[15:12]))
    else $error("manual range not used");
  auto_start_a: assert property (
    go && i_pwdata[15:12] >= 4'hC |=> o_adc_range == 4'h0)
    else $error("auto range not started low");
  range_step_a: assert property (o_adc_run && $past(o_adc_run) &&
    !$past(wr) && o_adc_range != $past(o_adc_range) && o_adc_range != 4'h0
    |-> o_adc_range == $past(o_adc_range) + 4'h1)
    else $error("range step not by one");
  range_top_a: assert property (o_adc_range <= 4'hB)
    else $error("range beyond top");
  conv_len_a: assert property (run_q <= LONG_CYC + 4)
    else $error("conversion too long");
  clear_pulse_a: assert property (o_adc_clear |=> !o_adc_clear)
    else $error("clear longer than one cycle");
  cover property ($fell(o_adc_run));
  cover property (o_adc_run && o_adc_range == 4'hB);
  cover property ($rose(o_irq));
endmodule
bind lcc_light_conv_ctrl lcc_checker #(.SHORT_CYC(SHORT_CYC),
  .LONG_CYC(LONG_CYC)) u_lcc_checker (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_adc_overload(i_adc_overload), .i_adc_mantissa(i_adc_mantissa),
  .o_adc_run(o_adc_run), .o_adc_clear(o_adc_clear),
  .o_adc_range(o_adc_range), .o_adc_long(o_adc_long), .o_irq(o_irq));
`default_nettype wire

// ---- sim/lcc_light_conv_ctrl_tb.sv ----
// Purpose: Self-checking bench for the light conversion control.
// Assumes: Conversions shortened to 20 and 50 cycles.
// Notes:   Random values come from a fixed-seed LFSR.
`default_nettype none
module lcc_light_conv_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 20;
  localparam int unsigned LC = 50;
  logic        clk, nrst, psel, pen, pwr, ovl, run, clr, lng, irq, rdy, err;
  logic        er;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, rd;
  logic [11:0] mant;
  logic [3:0]  rng;
  logic [31:0] lf = 32'hEDD2;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          nclr = 0;

  lcc_light_conv_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) u_lcc_light_conv_ctrl (
    .i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata),
    .o_pready(rdy), .o_pslverr(err), .i_adc_overload(ovl),
    .i_adc_mantissa(mant), .o_adc_run(run), .o_adc_clear(clr),
    .o_adc_range(rng), .o_adc_long(lng), .o_irq(irq));

  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // Counts restart pulses and cuts a hang short.
  always @(posedge clk)
  begin
    cyc++;
    if (clr === 1'b1) nclr++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [11:0] msk(input logic [3:0] e, input logic ct);
    if (ct || e > 4'h5) return 12'hFFF;
    return e == 4'h0 ? 12'hFF8 : e == 4'h5 ? 12'hFFE : 12'hFFC;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = rdata;
    er = err;
    psel <= 0;
    pen <= 0;
    // One idle edge, so a following transfer never re-drives psel at once.
    @(posedge clk);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // Single conversion; overload is held in auto mode, pulsed in manual.
  task automatic conv(input logic [3:0] rn, input logic ct, input logic ov);
    logic [3:0] e;
    logic       au;
    au = rn > 4'hB;
    e = (au && ov) ? 4'hB : au ? 4'h0 : rn;
    lf = nxt(lf);
    mant <= lf[11:0];
    ovl <= ov;
    nclr = 0;
    apb(1, 8'h00, {16'h0, rn, ct, 2'h1, 9'h0});
    apb(0, 8'h00, 0);
    chk(rd[10:9], 2'h1, "mode running");
    if (!au) repeat (4) @(posedge clk);
    if (!au) ovl <= 0;
    wait_irq();
    chk(irq, 1, "done irq");
    ovl <= 0;
    apb(0, 8'h04, 0);
    chk(rd, {16'h0, e, mant & msk(e, ct)}, "result");
    apb(0, 8'h00, 0);
    chk(rd, {16'h0, rn, ct, 2'h0, ov, 8'h0}, "config");
    chk(nclr, (au && ov) ? 12 : 1, "restarts");
    apb(1, 8'h08, 3);
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq clear");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    nrst = 0;
    {psel, pen, pwr, ovl, addr, wdata, mant} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    apb(0, 8'h00, 0);
    chk(rd, 32'h0000C800, "config reset");
    apb(0, 8'h0C, 0);
    chk(rd, 0, "mask reset");
    apb(0, 8'h10, 0);
    chk(er, 1, "unmapped");
    apb(1, 8'h0C, 1);
    // Reserved range codes above 1100b are never written by the host.
    for (int r = 0; r < 13; r++)
    begin
      lf = nxt(lf);
      conv(r[3:0], lf[5], lf[7]);
    end
    conv(4'hC, 1, 1);
    conv(4'h0, 0, 0);
    apb(1, 8'h0C, 0);
    apb(1, 8'h00, {16'h0, 4'h0, 1'h0, 2'h1, 9'h0});
    repeat (SC + 10) @(posedge clk);
    chk(irq, 0, "masked irq");
    apb(1, 8'h0C, 1);
    repeat (2) @(posedge clk);
    chk(irq, 1, "unmasked irq");
    apb(1, 8'h08, 3);
    apb(1, 8'h00, {16'h0, 4'h3, 1'h1, 2'h1, 9'h0});
    repeat (10) @(posedge clk);
    apb(1, 8'h00, {16'h0, 4'h3, 1'h1, 2'h0, 9'h0});
    repeat (2) @(posedge clk);
    chk(run, 0, "abort");
    repeat (LC + 10) @(posedge clk);
    apb(0, 8'h08, 0);
    chk(rd, 0, "no done after abort");
    for (int m = 2; m < 4; m++)
    begin
      apb(1, 8'h00, {16'h0, 4'h2, 1'h0, m[1:0], 9'h0});
      apb(1, 8'h08, 3);
      repeat (2 * SC + 10) @(posedge clk);
      apb(0, 8'h00, 0);
      chk(rd[10:9], m, "continuous mode");
      apb(0, 8'h08, 0);
      chk(rd[0], 1, "continuous done");
    end
    apb(1, 8'h00, 0);
    end_sim();
  end
endmodule
`default_nettype wire

// ---- verilog/lcc_conv_timer.sv ----
// Purpose: Times one conversion of 100 ms or 800 ms length.
// Assumes: A start restarts the count; abort stops it without a done.
// Notes:   o_done is a one-cycle pulse from a flip-flop.

`default_nettype none

module lcc_conv_timer #(
  parameter int unsigned SHORT_CYC = lcc_pkg::CONV_SHORT_CYC,
  parameter int unsigned LONG_CYC  = lcc_pkg::CONV_LONG_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_start,
  input  wire logic i_abort,
  input  wire logic i_long,
  output var  logic o_done
);

  // Counts that do not fit the down counter cannot be served.
  if (SHORT_CYC < 1 || LONG_CYC < 1 ||
      LONG_CYC >= (1 << lcc_pkg::CNT_W) ||
      SHORT_CYC >= (1 << lcc_pkg::CNT_W))
  begin : g_bad_cyc
    $error("lcc_conv_timer: cycle counts out of range");
  end

  logic [lcc_pkg::CNT_W-1:0] cnt_q;
  logic                      run_q;
  logic                      done_q;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (i_start)
    begin
      cnt_q <= i_long ? lcc_pkg::CNT_W'(LONG_CYC - 1)
                      : lcc_pkg::CNT_W'(SHORT_CYC - 1);
      run_q <= 1'b1;
    end
    else if (i_abort || (run_q && cnt_q == '0))
    begin
      run_q <= 1'b0;
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= run_q && (cnt_q == '0) && !i_start && !i_abort;
    end
  end

  assign o_done = done_q;

endmodule

`default_nettype wire

// ---- verilog/lcc_light_conv_ctrl.sv ----
// Purpose: Conversion control of an ambient light sensor with APB access.
// Assumes: The integrating converter sits outside; its overload level and
//          mantissa arrive asynchronously and pass two flip-flops here.
// Notes:   Config word 0x00, result 0x04, irq status 0x08, irq mask 0x0C.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.

`default_nettype none

module lcc_light_conv_ctrl #(
  parameter int unsigned SHORT_CYC = lcc_pkg::CONV_SHORT_CYC,
  parameter int unsigned LONG_CYC  = lcc_pkg::CONV_LONG_CYC
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [lcc_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output var  logic [31:0]               o_prdata,
  output var  logic                      o_pready,
  output var  logic                      o_pslverr,
  input  wire logic                      i_adc_overload,
  input  wire logic [11:0]               i_adc_mantissa,
  output var  logic                      o_adc_run,
  output var  logic                      o_adc_clear,
  output var  logic [3:0]                o_adc_range,
  output var  logic                      o_adc_long,
  output var  logic                      o_irq
);

  logic [3:0]          rn_q;
  logic                ct_q;
  logic [1:0]          mode_q;
  logic                ovf_q;
  logic [15:0]         result_q;
  logic [lcc_pkg::IRQ_W-1:0] sts_q;
  logic [lcc_pkg::IRQ_W-1:0] mask_q;
  logic [lcc_pkg::IRQ_W-1:0] sts_set;
  lcc_pkg::lcc_state_e state_q;
  logic [3:0]          range_q;
  logic                ovl_seen_q;
  logic                ovl_s1_q;
  logic                ovl_s2_q;
  logic [11:0]         mant_s1_q;
  logic [11:0]         mant_s2_q;
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;
  logic                run_q;
  logic                clear_q;
  logic                long_q;
  logic                irq_q;

  logic                setup;
  logic                access;
  logic                cfg_wr;
  logic                sts_wr;
  logic                mask_wr;
  logic                tmr_done;
  logic                conv_end;
  logic                ovl_final;
  logic                step_up;
  logic                finish;
  logic                cont_mode;
  logic                start_now;
  logic [3:0]          wr_rn;
  logic [1:0]          wr_mode;
  logic [3:0]          start_range;
  logic                start_long;
  logic [31:0]         rd_val;
  logic                rd_err;

  assign setup   = i_psel && !i_penable;
  assign access  = i_psel && i_penable && pready_q;
  assign cfg_wr  = access && i_pwrite && i_paddr == lcc_pkg::ADDR_CONFIG;
  assign sts_wr  = access && i_pwrite && i_paddr == lcc_pkg::ADDR_INT_STATUS;
  assign mask_wr = access && i_pwrite && i_paddr == lcc_pkg::ADDR_INT_MASK;

  assign wr_rn   = i_pwdata[lcc_pkg::RN_MSB:lcc_pkg::RN_LSB];
  assign wr_mode = i_pwdata[lcc_pkg::MODE_MSB:lcc_pkg::MODE_LSB];

  // A write to the config word wins over a conversion ending that cycle.
  assign conv_end  = state_q == lcc_pkg::ST_CONV && tmr_done && !cfg_wr;
  assign ovl_final = ovl_seen_q || ovl_s2_q;
  assign step_up   = conv_end && lcc_pkg::lcc_eff_rn(rn_q) == lcc_pkg::RN_AUTO
                     && ovl_final && range_q != lcc_pkg::RN_MAX;
  assign finish    = conv_end && !step_up;
  assign cont_mode = mode_q != lcc_pkg::MODE_SHUT &&
                     mode_q != lcc_pkg::MODE_ONCE;
  assign start_now = (cfg_wr && wr_mode != lcc_pkg::MODE_SHUT) ||
                     step_up || (finish && cont_mode);

  always_comb
  begin
    start_range = range_q;
    start_long  = ct_q;
    if (cfg_wr)
    begin
      start_long = i_pwdata[lcc_pkg::CT_BIT];
      if (lcc_pkg::lcc_eff_rn(wr_rn) == lcc_pkg::RN_AUTO)
      begin
        start_range = lcc_pkg::RN_MIN;
      end
      else
      begin
        start_range = wr_rn;
      end
    end
    else if (step_up)
    begin
      start_range = range_q + 4'h1;
    end
    else if (lcc_pkg::lcc_eff_rn(rn_q) == lcc_pkg::RN_AUTO)
    begin
      start_range = lcc_pkg::RN_MIN;
    end
    else
    begin
      start_range = rn_q;
    end
  end

  lcc_conv_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_timer (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_start (start_now),
    .i_abort (cfg_wr),
    .i_long  (start_long),
    .o_done  (tmr_done)
  );

  // Converter inputs are asynchronous to the clock.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ovl_s1_q  <= 1'b0;
      ovl_s2_q  <= 1'b0;
      mant_s1_q <= '0;
      mant_s2_q <= '0;
    end
    else
    begin
      ovl_s1_q  <= i_adc_overload;
      ovl_s2_q  <= ovl_s1_q;
      mant_s1_q <= i_adc_mantissa;
      mant_s2_q <= mant_s1_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q    <= lcc_pkg::ST_IDLE;
      range_q    <= lcc_pkg::RN_MIN;
      ovl_seen_q <= 1'b0;
    end
    else if (start_now)
    begin
      state_q    <= lcc_pkg::ST_CONV;
      range_q    <= start_range;
      ovl_seen_q <= 1'b0;
    end
    else if (cfg_wr || conv_end)
    begin
      state_q <= lcc_pkg::ST_IDLE;
    end
    else if (state_q == lcc_pkg::ST_CONV)
    begin
      ovl_seen_q <= ovl_final;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rn_q   <= lcc_pkg::RN_RESET;
      ct_q   <= lcc_pkg::CT_RESET;
      mode_q <= lcc_pkg::MODE_SHUT;
    end
    else if (cfg_wr)
    begin
      rn_q   <= wr_rn;
      ct_q   <= i_pwdata[lcc_pkg::CT_BIT];
      mode_q <= wr_mode;
    end
    else if (finish && mode_q == lcc_pkg::MODE_ONCE)
    begin
      mode_q <= lcc_pkg::MODE_SHUT;
    end
  end

  // Manual ranges flag any overload; auto flags it only at the top range.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ovf_q    <= 1'b0;
      result_q <= lcc_pkg::RESULT_RESET;
    end
    else if (finish)
    begin
      ovf_q    <= ovl_final;
      result_q <= {range_q,
                   ct_q ? mant_s2_q
                        : mant_s2_q & lcc_pkg::lcc_res_mask(range_q)};
    end
  end

  assign sts_set[lcc_pkg::IRQ_DONE_BIT] = finish;
  assign sts_set[lcc_pkg::IRQ_OVF_BIT]  = finish && ovl_final;

  // A status bit set in the same cycle as its clear stays set.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sts_q <= lcc_pkg::IRQ_RESET;
    end
    else if (sts_wr)
    begin
      sts_q <= (sts_q & ~i_pwdata[lcc_pkg::IRQ_W-1:0]) | sts_set;
    end
    else
    begin
      sts_q <= sts_q | sts_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mask_q <= lcc_pkg::IRQ_RESET;
    end
    else if (mask_wr)
    begin
      mask_q <= i_pwdata[lcc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(sts_q & mask_q);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      run_q   <= 1'b0;
      clear_q <= 1'b0;
      long_q  <= lcc_pkg::CT_RESET;
    end
    else
    begin
      run_q   <= start_now || (state_q == lcc_pkg::ST_CONV &&
                               !cfg_wr && !conv_end);
      clear_q <= start_now;
      if (start_now)
      begin
        long_q <= start_long;
      end
    end
  end

  always_comb
  begin
    rd_val = '0;
    rd_err = 1'b0;
    unique case (i_paddr)
      lcc_pkg::ADDR_CONFIG:
      begin
        rd_val[15:0] = {rn_q, ct_q, mode_q, ovf_q, 8'h00};
      end
      lcc_pkg::ADDR_RESULT:
      begin
        rd_val[15:0] = result_q;
      end
      lcc_pkg::ADDR_INT_STATUS:
      begin
        rd_val[lcc_pkg::IRQ_W-1:0] = sts_q;
      end
      lcc_pkg::ADDR_INT_MASK:
      begin
        rd_val[lcc_pkg::IRQ_W-1:0] = mask_q;
      end
      default:
      begin
        rd_err = 1'b1;
      end
    endcase
  end

  // Each transfer answers in its first access cycle.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= setup;
      pslverr_q <= setup && rd_err;
      if (setup && !i_pwrite)
      begin
        prdata_q <= rd_val;
      end
    end
  end

  assign o_prdata    = prdata_q;
  assign o_pready    = pready_q;
  assign o_pslverr   = pslverr_q;
  assign o_adc_run   = run_q;
  assign o_adc_clear = clear_q;
  assign o_adc_range = range_q;
  assign o_adc_long  = long_q;
  assign o_irq       = irq_q;

endmodule

`default_nettype wire

// ---- verilog/lcc_pkg.sv ----
// Purpose: Constants, types and helpers for the light conversion control.
// Assumes: 25 MHz clock, APB register access with 32-bit data.
// Notes:   The rules this block carries out are listed below.
// Operation
// - Range field bits 15:12 pick full scale, coded like result exponent.
// - Range code 1100b selects auto range, chosen range shown as exponent.
// - Range field resets to 1100b, so auto ranging is on after reset.
// - Bit 11 resets to one and picks 100 ms or 800 ms conversions.
// - Short time drops 1 bit at 0101b, 2 at 0001b-0100b, 3 at 0000b.
// - Result format and LSB weight do not depend on conversion time.
// - Mode bits 10:9 pick shutdown, single or continuous; reset 00b.
// - Single shot reads 01b while running, then self-clears to 00b.
// - Manual range sets overflow after any transient overload.
// - Auto range sets overflow only beyond the highest range.
// - Auto overflow below top range aborts, steps range up, restarts; the code steps up only once the full conversion time has run out.
// - Any config write aborts a conversion, then starts one if asked.

`default_nettype none

package lcc_pkg;

  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
  localparam logic [7:0]  ADDR_RESULT     = 8'h04;
  localparam logic [7:0]  ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_INT_MASK   = 8'h0C;

  localparam int unsigned RN_MSB   = 15;
  localparam int unsigned RN_LSB   = 12;
  localparam int unsigned CT_BIT   = 11;
  localparam int unsigned MODE_MSB = 10;
  localparam int unsigned MODE_LSB = 9;
  localparam int unsigned OVF_BIT  = 8;
  localparam int unsigned MANT_W   = 12;

  localparam logic [3:0] RN_AUTO   = 4'hC;
  localparam logic [3:0] RN_MAX    = 4'hB;
  localparam logic [3:0] RN_MIN    = 4'h0;
  localparam logic [3:0] RN_RESET  = 4'hC;
  localparam logic       CT_RESET  = 1'h1;
  localparam logic [1:0] MODE_SHUT = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_OVF_BIT  = 1;
  localparam logic [1:0]  IRQ_RESET    = 2'h0;

  localparam longint unsigned CLK_HZ        = 25000000;
  localparam longint unsigned CONV_SHORT_MS = 100;
  localparam longint unsigned CONV_LONG_MS  = 800;
  localparam int unsigned CONV_SHORT_CYC =
    int'((CONV_SHORT_MS * CLK_HZ) / 64'd1000);
  localparam int unsigned CONV_LONG_CYC =
    int'((CONV_LONG_MS * CLK_HZ) / 64'd1000);
  localparam int unsigned CNT_W = 25;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } lcc_state_e;

  // Low mantissa bits that carry no information with the short time.
  function automatic logic [11:0] lcc_res_mask(input logic [3:0] rng);
    logic [11:0] m;
    m = 12'hFFF;
    if (rng == 4'h0)
    begin
      m = 12'hFF8;
    end
    else if (rng <= 4'h4)
    begin
      m = 12'hFFC;
    end
    else if (rng == 4'h5)
    begin
      m = 12'hFFE;
    end
    return m;
  endfunction

  // Reserved range codes are served as automatic ranging.
  function automatic logic [3:0] lcc_eff_rn(input logic [3:0] rn);
    return (rn > RN_MAX) ? RN_AUTO : rn;
  endfunction

endpackage

`default_nettype wire
